// >>> hw/ctf_pkg.sv
// Constants and carrier types for the CAN timing and filter config block.
// Assumes a single 125 MHz clock and a plain strobe register port.
package ctf_pkg;
  localparam int unsigned ADDR_W = 3;
  // Register offsets (word index on the plain port)
  localparam logic [2:0] OFF_IRQ_EN = 3'h0;
  localparam logic [2:0] OFF_ERR_CNT = 3'h1;
  localparam logic [2:0] OFF_TIMING1 = 3'h2;
  localparam logic [2:0] OFF_TIMING2 = 3'h3;
  localparam logic [2:0] OFF_FILT_EN = 3'h4;
  localparam logic [2:0] OFF_TGT_0_3 = 3'h5;
  localparam logic [2:0] OFF_TGT_4_7 = 3'h6;
  localparam logic [2:0] OFF_TGT_8_11 = 3'h7;
  // Reset values and writable masks
  localparam logic [15:0] IRQ_EN_RST = 16'h0000;
  localparam logic [15:0] IRQ_EN_MASK = 16'h00ef;
  localparam logic [15:0] TIMING1_RST = 16'h0000;
  localparam logic [15:0] TIMING1_MASK = 16'h00ff;
  localparam logic [15:0] TIMING2_RST = 16'h0000;
  localparam logic [15:0] TIMING2_MASK = 16'h47ff;
  localparam logic [15:0] FILT_EN_RST = 16'h003f;
  localparam logic [15:0] TGT_RST = 16'h0000;
  localparam logic [15:0] ERR_CNT_RST = 16'h0000;
  // Enable bit position, target field width and FIFO target code
  localparam int unsigned BIT_ERR_EN = 5;
  localparam int unsigned TGT_W = 4;
  localparam logic [3:0] TGT_FIFO = 4'hf;
  // Processing delay in quanta, and wake filter time
  localparam logic [2:0] PROC_DELAY_TQ = 3'h2;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WAKE_FILT_NS = 80;
  localparam int unsigned WAKE_FILT_CYC =
    (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register port carrier
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ctf_bus_t;
  // First timing register layout
  typedef struct packed {
    logic [7:0] unused;
    logic [1:0] jump_width;
    logic [5:0] quantum_prescaler;
  } ctf_timing1_t;
  // Second timing register layout
  typedef struct packed {
    logic       unused15;
    logic       wake_line_filter_sel;
    logic [2:0] unused13;
    logic [2:0] phase_two_length;
    logic       phase_two_select;
    logic       triple_vote_sel;
    logic [2:0] phase_one_length;
    logic [2:0] propagation_length;
  } ctf_timing2_t;
  // Bit segment states
  typedef enum logic [3:0] {
    SEG_SYNC = 4'b0001,
    SEG_PROP = 4'b0010,
    SEG_PH1  = 4'b0100,
    SEG_PH2  = 4'b1000
  } ctf_seg_t;
endpackage

// >>> hw/ctf_regs.sv
// CAN bit timing, error counter and acceptance filter configuration block.
// Assumes clock-rate ticks for both core clock sources and a strobe port.
`timescale 1ns/100ps
`default_nettype none
module ctf_regs
  import ctf_pkg::*;
#(
  parameter int unsigned WAKE_CYC = ctf_pkg::WAKE_FILT_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire ctf_pkg::ctf_bus_t bus,
  output logic [15:0]            rdata,
  input  wire logic              core_clock_source,
  input  wire logic              instruction_cycle_tick,
  input  wire logic              oscillator_tick,
  input  wire logic [7:0]        tx_error_counter,
  input  wire logic [7:0]        rx_error_counter,
  input  wire logic [5:0]        error_state,
  input  wire logic [7:0]        irq_flags,
  input  wire logic              rx_line,
  input  wire logic [15:0]       filter_hit,
  input  wire logic [15:0]       upper_targets,
  output logic                   quantum_tick,
  output logic                   sample_point,
  output logic                   bit_end,
  output logic                   sampled_bit,
  output logic [2:0]             jump_width_tq,
  output logic                   wake_line,
  output logic                   store_valid,
  output logic [3:0]             store_filter,
  output logic [3:0]             store_buffer,
  output logic                   store_to_queue,
  output logic                   error_irq_flag,
  output logic                   irq_request
);
  import ctf_pkg::*;

  logic [15:0]  irq_en_q;
  logic [15:0]  err_cnt_q;
  ctf_timing1_t t1_q;
  ctf_timing2_t t2_q;
  logic [15:0]  filt_en_q;
  logic [15:0]  tgt_q [3];
  logic [15:0]  rdata_q;

  // Quantum length in core clock ticks
  function automatic logic [6:0] tq_len(input logic [5:0] p);
    tq_len = 7'(({1'b0, p} + 7'h01) << 1);
  endfunction

  // Lowest set bit of a hit vector
  function automatic logic [3:0] first_hit(input logic [15:0] v);
    first_hit = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        first_hit = 4'(i);
      end
    end
  endfunction

  // Effective phase two code
  function automatic logic [2:0] ph2_code(input ctf_timing2_t t);
    logic [2:0] d;
    d = PROC_DELAY_TQ - 3'h1;
    if (t.phase_two_select) begin
      ph2_code = t.phase_two_length;
    end else begin
      ph2_code = (t.phase_one_length > d) ? t.phase_one_length : d;
    end
  endfunction

  // Software writes; reserved bits are masked so they read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_q  <= IRQ_EN_RST;
      t1_q      <= TIMING1_RST;
      t2_q      <= TIMING2_RST;
      filt_en_q <= FILT_EN_RST;
      tgt_q[0]  <= TGT_RST;
      tgt_q[1]  <= TGT_RST;
      tgt_q[2]  <= TGT_RST;
    end else if (bus.wr) begin
      case (bus.addr)
        OFF_IRQ_EN:   irq_en_q <= bus.wdata & IRQ_EN_MASK;
        OFF_TIMING1:  t1_q <= bus.wdata & TIMING1_MASK;
        OFF_TIMING2:  t2_q <= bus.wdata & TIMING2_MASK;
        OFF_FILT_EN:  filt_en_q <= bus.wdata;
        OFF_TGT_0_3:  tgt_q[0] <= bus.wdata;
        OFF_TGT_4_7:  tgt_q[1] <= bus.wdata;
        OFF_TGT_8_11: tgt_q[2] <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Error counters are mirrored from the protocol engine every cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_cnt_q <= ERR_CNT_RST;
    end else begin
      err_cnt_q <= {tx_error_counter, rx_error_counter};
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (bus.rd) begin
      case (bus.addr)
        OFF_IRQ_EN:   rdata_q <= irq_en_q;
        OFF_ERR_CNT:  rdata_q <= err_cnt_q;
        OFF_TIMING1:  rdata_q <= t1_q;
        OFF_TIMING2:  rdata_q <= t2_q;
        OFF_FILT_EN:  rdata_q <= filt_en_q;
        OFF_TGT_0_3:  rdata_q <= tgt_q[0];
        OFF_TGT_4_7:  rdata_q <= tgt_q[1];
        OFF_TGT_8_11: rdata_q <= tgt_q[2];
        default:      rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign rdata = rdata_q;

  // Quantum prescaler counting ticks of the selected core clock
  logic       src_tick;
  logic [6:0] pre_cnt_q;
  logic       tq_q;
  assign src_tick = core_clock_source ? instruction_cycle_tick
                                      : oscillator_tick;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt_q <= 7'h00;
      tq_q      <= 1'b0;
    end else if (src_tick) begin
      if (pre_cnt_q >= tq_len(t1_q.quantum_prescaler) - 7'h01) begin
        pre_cnt_q <= 7'h00;
        tq_q      <= 1'b1;
      end else begin
        pre_cnt_q <= pre_cnt_q + 7'h01;
        tq_q      <= 1'b0;
      end
    end else begin
      tq_q <= 1'b0;
    end
  end
  assign quantum_tick = tq_q;

  // Segment sequencer; no resync here, the protocol engine owns edges
  ctf_seg_t   seg_q;
  logic [2:0] qcnt_q;
  logic [2:0] seg_code;
  logic       seg_done;
  always_comb begin
    case (seg_q)
      SEG_SYNC: seg_code = 3'h0;
      SEG_PROP: seg_code = t2_q.propagation_length;
      SEG_PH1:  seg_code = t2_q.phase_one_length;
      SEG_PH2:  seg_code = ph2_code(t2_q);
      default:  seg_code = 3'h0;
    endcase
  end
  assign seg_done = tq_q && (qcnt_q == seg_code);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seg_q  <= SEG_SYNC;
      qcnt_q <= 3'h0;
    end else if (tq_q) begin
      if (seg_done) begin
        qcnt_q <= 3'h0;
        case (seg_q)
          SEG_SYNC: seg_q <= SEG_PROP;
          SEG_PROP: seg_q <= SEG_PH1;
          SEG_PH1:  seg_q <= SEG_PH2;
          SEG_PH2:  seg_q <= SEG_SYNC;
          default:  seg_q <= SEG_SYNC;
        endcase
      end else begin
        qcnt_q <= qcnt_q + 3'h1;
      end
    end
  end

  // Line history for the three-sample vote, one entry per quantum
  logic [1:0] hist_q;
  logic       vote;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_q <= 2'b11;
    end else if (tq_q) begin
      hist_q <= {hist_q[0], rx_line};
    end
  end
  assign vote = (hist_q[1] & hist_q[0]) | (hist_q[1] & rx_line)
              | (hist_q[0] & rx_line);

  // Sample point strobe and the bit value taken there
  logic samp_q;
  logic bit_q;
  logic end_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      samp_q <= 1'b0;
      bit_q  <= 1'b1;
      end_q  <= 1'b0;
    end else begin
      samp_q <= seg_done && (seg_q == SEG_PH1);
      end_q  <= seg_done && (seg_q == SEG_PH2);
      if (seg_done && (seg_q == SEG_PH1)) begin
        bit_q <= t2_q.triple_vote_sel ? vote : rx_line;
      end
    end
  end
  assign sample_point = samp_q;
  assign sampled_bit  = bit_q;
  assign bit_end      = end_q;

  // Jump width in quanta for the resync logic
  logic [2:0] sjw_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sjw_q <= 3'h1;
    end else begin
      sjw_q <= {1'b0, t1_q.jump_width} + 3'h1;
    end
  end
  assign jump_width_tq = sjw_q;

  // Wake filter: a level must hold WAKE_CYC cycles to pass, so short
  // glitches cannot wake the node; costs that latency on real edges
  logic [15:0] wk_cnt_q;
  logic        wk_filt_q;
  logic        wk_out_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wk_cnt_q  <= 16'h0000;
      wk_filt_q <= 1'b1;
      wk_out_q  <= 1'b1;
    end else begin
      if (rx_line == wk_filt_q) begin
        wk_cnt_q <= 16'h0000;
      end else if (wk_cnt_q >= 16'(WAKE_CYC - 1)) begin
        wk_cnt_q  <= 16'h0000;
        wk_filt_q <= rx_line;
      end else begin
        wk_cnt_q <= wk_cnt_q + 16'h0001;
      end
      wk_out_q <= t2_q.wake_line_filter_sel ? wk_filt_q : rx_line;
    end
  end
  assign wake_line = wk_out_q;

  // Acceptance: lowest enabled hit wins when several filters match
  logic [15:0] hits;
  logic [3:0]  win;
  logic [3:0]  win_tgt;
  logic [63:0] all_tgt;
  assign hits    = filter_hit & filt_en_q;
  assign win     = first_hit(hits);
  assign all_tgt = {upper_targets, tgt_q[2], tgt_q[1], tgt_q[0]};
  assign win_tgt = all_tgt[{win, 2'b00} +: TGT_W];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      store_valid    <= 1'b0;
      store_filter   <= 4'h0;
      store_buffer   <= 4'h0;
      store_to_queue <= 1'b0;
    end else begin
      store_valid    <= |hits;
      store_filter   <= win;
      store_buffer   <= win_tgt;
      store_to_queue <= (|hits) && (win_tgt == TGT_FIFO);
    end
  end

  // Error flag and module request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_irq_flag <= 1'b0;
      irq_request    <= 1'b0;
    end else begin
      error_irq_flag <= |error_state;
      irq_request    <= |(irq_flags & irq_en_q[7:0])
                      | ((|error_state) & irq_en_q[BIT_ERR_EN]);
    end
  end

  // Checks
  rsv_zero_a: assert property (@(posedge clk) disable iff (rst)
    (irq_en_q[15:8] == 8'h00) && !irq_en_q[4])
    else $error("reserved enable bits set");
  en_write_a: assert property (@(posedge clk) disable iff (rst)
    bus.wr && bus.addr == OFF_IRQ_EN |=> irq_en_q[3:0] == $past(bus.wdata[3:0]))
    else $error("enable write lost");
  cnt_read_a: assert property (@(posedge clk) disable iff (rst)
    bus.rd && bus.addr == OFF_ERR_CNT |=> rdata == $past(err_cnt_q))
    else $error("counter read wrong");
  sjw_val_a: assert property (@(posedge clk) disable iff (rst)
    sjw_q == {1'b0, $past(t1_q.jump_width)} + 3'h1)
    else $error("jump width wrong");
  tq_space_a: assert property (@(posedge clk) disable iff (rst)
    tq_q && core_clock_source && instruction_cycle_tick && !oscillator_tick
    && t1_q.quantum_prescaler == 6'h00 && !bus.wr
    |=> !tq_q ##1 tq_q)
    else $error("quantum spacing wrong");
  ph2_len_a: assert property (@(posedge clk) disable iff (rst)
    seg_q == SEG_PH2 && seg_done |-> qcnt_q == ph2_code(t2_q))
    else $error("phase two length wrong");
  seg_order_a: assert property (@(posedge clk) disable iff (rst)
    seg_done && seg_q == SEG_PH1 |=> samp_q && seg_q == SEG_PH2)
    else $error("sample point misplaced");
  vote_once_a: assert property (@(posedge clk) disable iff (rst)
    seg_done && seg_q == SEG_PH1 && !t2_q.triple_vote_sel
    |=> bit_q == $past(rx_line))
    else $error("single sample wrong");
  wake_pass_a: assert property (@(posedge clk) disable iff (rst)
    !t2_q.wake_line_filter_sel |=> wk_out_q == $past(rx_line))
    else $error("wake bypass wrong");
  accept_a: assert property (@(posedge clk) disable iff (rst)
    (filter_hit & filt_en_q) == 16'h0000 |=> !store_valid)
    else $error("disabled filter accepted");
  queue_a: assert property (@(posedge clk) disable iff (rst)
    store_valid |-> store_to_queue == (store_buffer == TGT_FIFO))
    else $error("queue routing wrong");
  req_a: assert property (@(posedge clk) disable iff (rst)
    |(irq_flags & irq_en_q[7:0]) |=> irq_request)
    else $error("request missing");
  err_flag_a: assert property (@(posedge clk) disable iff (rst)
    |error_state |=> error_irq_flag)
    else $error("error flag missing");
  seg_len_a: assert property (@(posedge clk) disable iff (rst)
    seg_q == SEG_PROP && seg_done |-> qcnt_q == t2_q.propagation_length)
    else $error("propagation length wrong");
  ph1_len_a: assert property (@(posedge clk) disable iff (rst)
    seg_q == SEG_PH1 && seg_done |-> qcnt_q == t2_q.phase_one_length)
    else $error("phase one length wrong");
  ph2_prog_a: assert property (@(posedge clk) disable iff (rst)
    seg_q == SEG_PH2 && seg_done && t2_q.phase_two_select
    |-> qcnt_q == t2_q.phase_two_length)
    else $error("programmed phase two wrong");
  tgt_map_a: assert property (@(posedge clk) disable iff (rst)
    filter_hit == 16'h0001 && filt_en_q[0] |=> store_buffer == $past(tgt_q[0][3:0]))
    else $error("pointer map wrong");
endmodule
`default_nettype wire

// >>> verification/ctf_node_model.sv
// Behavioural stand-in for the other nodes and the protocol engine.
// Assumes the bench pulses fault once per bus error and sets line_lvl.
`timescale 1ns/100ps
`default_nettype none
module ctf_node_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fault,
  input  wire logic       line_lvl,
  output logic            rx_line,
  output logic [7:0]      tx_error_counter,
  output logic [7:0]      rx_error_counter,
  output logic [5:0]      error_state
);
  // Transmit side gains eight per error, receive side one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_error_counter <= 8'h00;
      rx_error_counter <= 8'h00;
      rx_line          <= 1'b1;
    end else begin
      rx_line <= line_lvl;
      if (fault) begin
        tx_error_counter <= tx_error_counter + 8'h08;
        rx_error_counter <= rx_error_counter + 8'h01;
      end
    end
  end
  // Warning indications only; passive and bus-off never reached here
  assign error_state = {4'h0, rx_error_counter >= 8'h60, tx_error_counter >= 8'h60};
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the timing and filter config block.
// Assumes the strobe register port and a shortened wake filter.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ctf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, src = 1'b1, itick = 1'b1, otick = 1'b0;
  logic fault = 1'b0, line_lvl = 1'b1, rx_line;
  logic [7:0] txc, rxc, flags = 8'h00;
  logic [5:0] est;
  logic [15:0] rdata, hits = 16'h0000;
  logic qt, sp, be, sbit, wake, sv, stq, eflag, irq;
  logic [2:0] jw;
  logic [3:0] sf, sb;
  ctf_bus_t bus = '0;
  int err_count = 0, total_checks = 0, n, i;
  logic [15:0] rst_v [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h003f, 16'h0, 16'h0, 16'h0};
  logic [15:0] one_v [8] = '{16'h00ef, 16'h0, 16'h00ff, 16'h47ff, 16'hffff, 16'hffff,
                             16'hffff, 16'hffff};

  always #4 clk = ~clk;
  // Slow source ticks every second clock
  always @(posedge clk) otick <= ~otick;

  ctf_node_model node_u (.clk(clk), .rst(rst), .fault(fault), .line_lvl(line_lvl),
    .rx_line(rx_line), .tx_error_counter(txc), .rx_error_counter(rxc), .error_state(est));

  ctf_regs #(.WAKE_CYC(2)) dut_u (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .core_clock_source(src), .instruction_cycle_tick(itick), .oscillator_tick(otick),
    .tx_error_counter(txc), .rx_error_counter(rxc), .error_state(est),
    .irq_flags(flags), .rx_line(rx_line), .filter_hit(hits), .upper_targets(16'h0000),
    .quantum_tick(qt), .sample_point(sp), .bit_end(be), .sampled_bit(sbit),
    .jump_width_tq(jw), .wake_line(wake), .store_valid(sv), .store_filter(sf),
    .store_buffer(sb), .store_to_queue(stq), .error_irq_flag(eflag), .irq_request(irq));

  task automatic wrap_up();
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return qt;
      1: return sp;
      default: return be;
    endcase
  endfunction

  // Cycles from one pulse of s0 to the next pulse of s1, bounded
  task automatic span(input int s0, input int s1, output int c);
    int k;
    k = 0;
    while (pick(s0) !== 1'b1 && k < 500) begin
      @(posedge clk);
      #1 k++;
    end
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (pick(s1) !== 1'b1 && c < 500);
  endtask

  // One hit vector, then the store result of the next cycle
  task automatic hit(input logic [15:0] v, input logic [9:0] e);
    @(posedge clk);
    hits <= v;
    @(posedge clk);
    hits <= 16'h0;
    #1 chk("store", {6'h0, e}, {6'h0, sv, sf, sb, stq});
  endtask

  initial begin
    #400000;
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) rd(i[2:0], rst_v[i]);
    // Reserved bits drop, counters ignore writes
    for (i = 0; i < 8; i++) wr(i[2:0], 16'hffff);
    for (i = 0; i < 8; i++) rd(i[2:0], one_v[i]);
    for (i = 0; i < 4; i++) begin
      wr(OFF_TIMING1, {8'h0, i[1:0], 6'h0});
      settle();
      chk("jump", 16'(i + 1), {13'h0, jw});
    end
    wr(OFF_TIMING1, 16'h0003);
    span(0, 0, n);
    span(0, 0, n);
    chk("quantum fast", 16'd8, 16'(n));
    @(posedge clk);
    src <= 1'b0;
    span(0, 0, n);
    span(0, 0, n);
    chk("quantum slow", 16'd16, 16'(n));
    @(posedge clk);
    src <= 1'b1;
    wr(OFF_TIMING1, 16'h0000);
    wr(OFF_TIMING2, 16'h0391);
    span(2, 2, n);
    span(2, 2, n);
    chk("bit time", 16'd20, 16'(n));
    span(1, 2, n);
    chk("phase two", 16'd8, 16'(n));
    wr(OFF_TIMING2, 16'h0311);
    span(2, 2, n);
    span(2, 2, n);
    chk("bit time auto", 16'd18, 16'(n));
    // Filters 1 and 5 only; lowest enabled index wins
    wr(OFF_FILT_EN, 16'h0022);
    wr(OFF_TGT_0_3, 16'h0e30);
    wr(OFF_TGT_4_7, 16'h00f0);
    hit(16'h0001, 10'h000);
    hit(16'h0026, {1'b1, 4'h1, 4'h3, 1'b0});
    hit(16'h0020, {1'b1, 4'h5, 4'hf, 1'b1});
    @(posedge clk);
    flags <= 8'h10;
    settle();
    chk("irq reserved", 16'h0, {15'h0, irq});
    @(posedge clk);
    flags <= 8'h04;
    settle();
    chk("irq on", 16'h1, {15'h0, irq});
    wr(OFF_IRQ_EN, 16'h00eb);
    settle();
    chk("irq masked", 16'h0, {15'h0, irq});
    @(posedge clk);
    flags <= 8'h00;
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      fault <= 1'b1;
    end
    @(posedge clk);
    fault <= 1'b0;
    settle();
    rd(OFF_ERR_CNT, 16'h600c);
    chk("error flag", 16'h1, {15'h0, eflag});
    chk("irq error", 16'h1, {15'h0, irq});
    wr(OFF_IRQ_EN, 16'h0000);
    settle();
    chk("irq off", 16'h0, {15'h0, irq});
    // Dominant line through the vote and the wake filter
    wr(OFF_TIMING2, 16'h4351);
    line_lvl <= 1'b0;
    repeat (40) @(posedge clk);
    #1 chk("sampled", 16'h0, {15'h0, sbit});
    chk("wake", 16'h0, {15'h0, wake});
    wrap_up();
  end
endmodule
`default_nettype wire
